// File: rtl/accel_event_status_regs.sv
`timescale 1ns/1ns
module accel_event_status_regs #(
    parameter logic [6:0]  SLAVE_ADDR  = 7'h15,
    parameter logic [10:0] THRESH_CNTS = 11'(accel_evt_pkg::XY_THRESH_COUNTS)
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         scl_i,
    input  wire logic                         sda_i,
    output      logic                         sda_o,
    output      logic                         sda_oe_o,
    input  wire logic [3:0]                   shake_det_i,
    input  wire logic                         sample_valid_i,
    input  wire accel_evt_pkg::accel_sample_t sample_i,
    input  wire accel_evt_pkg::irq_enable_t   irq_enable_i,
    output      logic                         int_o,
    output      logic                         soft_reset_o
);
    import accel_evt_pkg::*;

    // The slave address default is arbitrary.
    if (THRESH_CNTS == 11'h000)
    begin : g_bad_thresh
        $error("Orientation threshold must be above zero.");
    end

    // ================================================================
    // Pin synchronisers and bus condition detection
    logic scl_m_q;
    logic scl_s_q;
    logic scl_p_q;
    logic sda_m_q;
    logic sda_s_q;
    logic sda_p_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;

    assign start_cond = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_cond  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign scl_rise   = scl_s_q & ~scl_p_q;
    assign scl_fall   = ~scl_s_q & scl_p_q;

    // ================================================================
    // Status storage declarations
    logic [3:0] shake_q;
    logic       z_chg_q;
    logic       xy_chg_q;
    logic [1:0] xy_code_q;
    logic       z_neg_q;
    logic       tilt_q;
    logic       ready_q;
    logic [7:0] clr0_q;
    logic [7:0] clr1_q;
    logic       swrst_pend_q;
    logic       core_rst;

    function automatic logic [10:0] mag12(input logic signed [11:0] v);
        logic [11:0] a;
        a = v[11] ? 12'(-v) : 12'(v);
        // The most negative value saturates rather than wrapping.
        mag12 = a[11] ? 11'h7FF : a[10:0];
    endfunction

    function automatic logic [7:0] read_byte(input logic [7:0] ptr);
        logic [7:0] b;
        b = BYTE_RESET;
        case (ptr)
            EVT_REG_OFS:                                          // [RL3]
            begin
                b[Z_CHG_BIT]  = z_chg_q;
                b[XY_CHG_BIT] = xy_chg_q;
                b[3:0]        = shake_q;
            end
            ORI_REG_OFS:                                          // [RL5]
            begin
                b[TILT_BIT]                      = tilt_q;
                b[ZDIR_BIT]                      = z_neg_q;
                b[XY_CODE_LSB +: 2]              = xy_code_q;
                b[READY_BIT]                     = ready_q;
            end
            // Other registers of the map live outside this block.
            default: b = BYTE_RESET;                              // [RL1]
        endcase
        read_byte = b;
    endfunction

    // ================================================================
    // Serial slave; kept out of the soft reset so the command is acked
    link_state_t st_q;
    logic [3:0]  bits_q;
    logic [7:0]  sh_q;
    logic        rw_q;
    logic        first_q;
    logic [7:0]  ptr_q;
    logic        wr_stb_q;
    logic [7:0]  wr_addr_q;
    logic [7:0]  wr_data_q;
    logic [7:0]  tx_byte;

    // A process, not an assign: the function reads the flags directly, and
    // only a process wakes up when they change under a fixed pointer.
    always_comb
    begin
        tx_byte = read_byte(ptr_q);
    end

    always_ff @(posedge clk_i)
    begin
        wr_stb_q <= 1'b0;
        if (rst_i)
        begin
            st_q      <= ST_IDLE;
            bits_q    <= 4'h0;
            sh_q      <= BYTE_RESET;
            rw_q      <= 1'b0;
            first_q   <= 1'b0;
            ptr_q     <= BYTE_RESET;
            sda_oe_o  <= 1'b0;
            wr_addr_q <= BYTE_RESET;
            wr_data_q <= BYTE_RESET;
        end
        else if (start_cond)
        begin
            st_q     <= ST_ADDR;
            bits_q   <= 4'h0;
            sda_oe_o <= 1'b0;
        end
        else if (stop_cond)
        begin
            st_q     <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        sh_q   <= {sh_q[6:0], sda_s_q};
                        bits_q <= bits_q + 4'h1;
                    end
                    else if (scl_fall && bits_q == BITS_PER_BYTE)
                    begin
                        bits_q <= 4'h0;
                        if (st_q == ST_ADDR)
                        begin
                            if (sh_q[7:1] == SLAVE_ADDR)
                            begin
                                sda_oe_o <= 1'b1;
                                rw_q     <= sh_q[0];
                                first_q  <= ~sh_q[0];
                                st_q     <= ST_ACK_ADDR;
                            end
                            else
                            begin
                                st_q <= ST_IDLE;
                            end
                        end
                        else
                        begin
                            sda_oe_o <= 1'b1;
                            st_q     <= ST_ACK_WR;
                            if (first_q)
                            begin
                                ptr_q   <= sh_q;                  // [RL18]
                                first_q <= 1'b0;
                            end
                            else
                            begin
                                wr_stb_q  <= 1'b1;
                                wr_addr_q <= ptr_q;
                                wr_data_q <= sh_q;
                                ptr_q     <= ptr_q + 8'h01;       // [RL18]
                            end
                        end
                    end
                end
                ST_ACK_ADDR:
                begin
                    if (scl_fall)
                    begin
                        if (rw_q)
                        begin
                            sh_q     <= {tx_byte[6:0], 1'b0};     // [RL19]
                            sda_oe_o <= ~tx_byte[7];
                            bits_q   <= 4'h1;
                            st_q     <= ST_TX;
                        end
                        else
                        begin
                            sda_oe_o <= 1'b0;
                            st_q     <= ST_RX;
                        end
                    end
                end
                ST_ACK_WR:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_o <= 1'b0;
                        st_q     <= ST_RX;
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bits_q == BITS_PER_BYTE)
                        begin
                            sda_oe_o <= 1'b0;
                            ptr_q    <= ptr_q + 8'h01;            // [RL19]
                            st_q     <= ST_ACK_RD;
                        end
                        else
                        begin
                            sda_oe_o <= ~sh_q[7];
                            sh_q     <= {sh_q[6:0], 1'b0};
                            bits_q   <= bits_q + 4'h1;
                        end
                    end
                end
                ST_ACK_RD:
                begin
                    if (scl_rise && sda_s_q)
                    begin
                        // A missing ack ends the read; wait for stop.
                        st_q <= ST_IDLE;
                    end
                    else if (scl_fall)
                    begin
                        sh_q     <= {tx_byte[6:0], 1'b0};         // [RL19]
                        sda_oe_o <= ~tx_byte[7];
                        bits_q   <= 4'h1;
                        st_q     <= ST_TX;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        // Open drain: only the enable moves, the data stays low.
        sda_o <= 1'b0;
    end

    // ================================================================
    // Soft reset, applied only once the bus is idle
    logic soft_active;

    assign soft_active = swrst_pend_q & (st_q == ST_IDLE);        // [RL20]
    assign core_rst    = rst_i | soft_active;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_active)
        begin
            swrst_pend_q <= 1'b0;
        end
        else if (clr1_q[SOFT_RST_BIT])
        begin
            swrst_pend_q <= 1'b1;                                 // [RL6]
        end
        soft_reset_o <= ~rst_i & soft_active;
    end

    // ================================================================
    // Write-only clear strobes; they live for one cycle only
    always_ff @(posedge clk_i)
    begin
        if (core_rst)
        begin
            clr0_q <= BYTE_RESET;                                 // [RL23]
            clr1_q <= BYTE_RESET;
        end
        else
        begin
            // Writes never touch the readable flags directly.    [RL7]
            clr0_q <= (wr_stb_q && wr_addr_q == EVT_REG_OFS)
                      ? wr_data_q : BYTE_RESET;                   // [RL4] [RL10]
            clr1_q <= (wr_stb_q && wr_addr_q == ORI_REG_OFS)
                      ? wr_data_q : BYTE_RESET;                   // [RL6] [RL10]
        end
    end

    // ================================================================
    // Event flags; a new event outranks a clear in the same cycle, except a shake on an axis already flagged
    logic [3:0] shake_set;
    logic [1:0] xy_code_new;
    logic       xy_update;
    logic [10:0] ax_mag;
    logic [10:0] ay_mag;

    assign ax_mag    = mag12(sample_i.ax);
    assign ay_mag    = mag12(sample_i.ay);
    assign shake_set = shake_det_i & ~shake_q;                    // [RL12] [RL13]
    assign xy_update = sample_valid_i &&
                       ((ax_mag >= ay_mag ? ax_mag : ay_mag) > THRESH_CNTS);

    always_comb
    begin
        if (ax_mag >= ay_mag)                                     // [RL16]
        begin
            xy_code_new = sample_i.ax[11] ? XY_NEG_X : XY_POS_X;
        end
        else
        begin
            xy_code_new = sample_i.ay[11] ? XY_NEG_Y : XY_POS_Y;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (core_rst)
        begin
            shake_q   <= 4'h0;                                    // [RL23]
            z_chg_q   <= 1'b0;
            xy_chg_q  <= 1'b0;
            xy_code_q <= XY_POS_X;
            z_neg_q   <= 1'b0;
            tilt_q    <= 1'b0;
            ready_q   <= 1'b0;
        end
        else
        begin
            // Clear bits written as zero leave flags alone.      [RL11]
            shake_q  <= (shake_q & ~clr0_q[3:0]) | shake_set;     // [RL8] [RL10]
            z_chg_q  <= (z_chg_q & ~clr0_q[Z_CHG_BIT]) |
                        (sample_valid_i && sample_i.z_neg != z_neg_q); // [RL15]
            xy_chg_q <= (xy_chg_q & ~clr0_q[XY_CHG_BIT]) |
                        (xy_update && xy_code_new != xy_code_q);  // [RL14]
            ready_q  <= (ready_q & ~clr1_q[READY_CLR_BIT]) |
                        sample_valid_i;                           // [RL21]
            if (xy_update)
            begin
                xy_code_q <= xy_code_new;                         // [RL17]
            end
            if (sample_valid_i)
            begin
                z_neg_q <= sample_i.z_neg;
                tilt_q  <= sample_i.tilt;
            end
        end
    end

    // ================================================================
    // Interrupt pin, active high
    always_ff @(posedge clk_i)
    begin
        if (core_rst)
        begin
            int_o <= 1'b0;
        end
        else
        begin
            int_o <= |(shake_q & irq_enable_i.shake) |            // [RL8] [RL22]
                     (z_chg_q & irq_enable_i.z_chg) |
                     (xy_chg_q & irq_enable_i.xy_chg) |
                     (ready_q & irq_enable_i.ready);
        end
    end

endmodule

// File: inc/accel_evt_pkg.sv
// What this block does
// RL1 - Sixteen byte registers at 0x00 to 0x0F
// RL2 - Master never holds both lines low 10ms
// RL3 - Read 0x00 returns change and shake flags
// RL4 - Write 0x00 clears change and shake flags
// RL5 - Read 0x01 returns tilt, Z, XY, ready
// RL6 - Write 0x01 clears ready, requests soft reset
// RL7 - Shared addresses: reads source, writes clear
// RL8 - Events set source bit and raise interrupt
// RL9 - Master reads cause, services, then clears
// RL10 - Writing one clears source, clear self-clears
// RL11 - Clear bit zero leaves source bit alone
// RL12 - Shake in a direction sets its flag
// RL13 - Set shake flag locks out that axis
// RL14 - XY orientation change sets XY flag
// RL15 - Z direction change sets Z flag
// RL16 - XY code 00 +X, 01 +Y, 10 -X, 11 -Y
// RL17 - XY code updates only above 0.375g
// RL18 - Write: address, pointer, data, pointer increments
// RL19 - Read: pointer, repeated start, data, increments
// RL20 - Soft reset waits for transfer, spares serial logic
// RL21 - Ready flag sets on each new measurement
// RL22 - Interrupt holds while enabled source bits set
// RL23 - Flags and fields reset to zero
package accel_evt_pkg;

    // ================================================================
    // Register map
    localparam logic [7:0] EVT_REG_OFS  = 8'h00;
    localparam logic [7:0] ORI_REG_OFS  = 8'h01;
    localparam logic [7:0] LAST_REG_OFS = 8'h0F;

    // ================================================================
    // Field positions
    localparam int Z_CHG_BIT     = 7;
    localparam int XY_CHG_BIT    = 6;
    localparam int TILT_BIT      = 7;
    localparam int ZDIR_BIT      = 6;
    localparam int XY_CODE_LSB   = 4;
    localparam int READY_BIT     = 0;
    localparam int READY_CLR_BIT = 0;
    localparam int SOFT_RST_BIT  = 4;

    // ================================================================
    // Reset values and encodings
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] XY_POS_X   = 2'h0;
    localparam logic [1:0] XY_POS_Y   = 2'h1;
    localparam logic [1:0] XY_NEG_X   = 2'h2;
    localparam logic [1:0] XY_NEG_Y   = 2'h3;

    // ================================================================
    // Orientation threshold, in milli-g and in output counts
    localparam int ONE_G_COUNTS    = 1024;
    localparam int XY_THRESH_MG    = 375;
    localparam int XY_THRESH_COUNTS = ONE_G_COUNTS * XY_THRESH_MG / 1000;

    // ================================================================
    // Serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic signed [11:0] ax;
        logic signed [11:0] ay;
        logic               z_neg;
        logic               tilt;
    } accel_sample_t;

    typedef struct packed {
        logic       z_chg;
        logic       xy_chg;
        logic [3:0] shake;
        logic       ready;
    } irq_enable_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_RX,
        ST_ACK_WR,
        ST_TX,
        ST_ACK_RD
    } link_state_t;

endpackage

// File: testbench/accel_event_status_regs_asserts.sv
`timescale 1ns/1ns
module accel_event_status_regs_asserts #(
    parameter logic [6:0]  SLAVE_ADDR  = 7'h15,
    parameter logic [10:0] THRESH_CNTS = 11'h180
) (
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       scl_i,
    input wire logic                       sda_i,
    input wire logic                       sda_o,
    input wire logic                       sda_oe_o,
    input wire logic [3:0]                 shake_det_i,
    input wire logic                       sample_valid_i,
    input wire accel_evt_pkg::accel_sample_t sample_i,
    input wire accel_evt_pkg::irq_enable_t irq_enable_i,
    input wire logic                       int_o,
    input wire logic                       soft_reset_o
);
    import accel_evt_pkg::*;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ================================================================
    // Interrupt path
    a_shake_irq: assert property (
        |(shake_det_i & irq_enable_i.shake) |-> ##2 int_o)
        else $error("shake did not raise int_o");
    a_ready_irq: assert property (
        sample_valid_i && irq_enable_i.ready |-> ##2 int_o)
        else $error("new sample did not raise int_o");
    a_masked_quiet: assert property (
        (irq_enable_i == 7'h00) [*3] |-> !int_o)
        else $error("int_o high with all sources masked");
    a_int_cause: assert property (
        int_o |-> $past(irq_enable_i) != 7'h00)
        else $error("int_o high with no enabled source");

    // ================================================================
    // Serial pins and resets
    a_sda_open: assert property (
        !sda_o)
        else $error("sda_o driven high");
    a_oe_steady: assert property (
        scl_i [*3] |-> $stable(sda_oe_o))
        else $error("sda_oe_o moved while SCL high");
    a_reset_quiet: assert property (
        disable iff (1'b0) rst_i |=> !sda_oe_o && !int_o && !soft_reset_o)
        else $error("outputs active after reset");
    a_soft_pulse: assert property (
        soft_reset_o |=> !soft_reset_o)
        else $error("soft reset longer than one cycle");
    a_soft_idle: assert property (
        soft_reset_o |-> scl_i && sda_i)
        else $error("soft reset applied while bus busy");

    c_shake: cover property (|shake_det_i && int_o);
    c_soft: cover property (soft_reset_o);
    c_ack: cover property ($rose(sda_oe_o));
    c_int_drop: cover property ($fell(int_o));
endmodule

bind accel_event_status_regs accel_event_status_regs_asserts #(
    .SLAVE_ADDR  (SLAVE_ADDR),
    .THRESH_CNTS (THRESH_CNTS)
) u_chk (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .scl_i          (scl_i),
    .sda_i          (sda_i),
    .sda_o          (sda_o),
    .sda_oe_o       (sda_oe_o),
    .shake_det_i    (shake_det_i),
    .sample_valid_i (sample_valid_i),
    .sample_i       (sample_i),
    .irq_enable_i   (irq_enable_i),
    .int_o          (int_o),
    .soft_reset_o   (soft_reset_o)
);

// File: testbench/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output      logic scl_o,
    output      logic sda_low_o
);
    // Open drain: the model only pulls low, the pull-up gives the high.
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // A quarter of the 800 ns serial period, on falling clk edges.
    task automatic quarter();
        repeat (2) @(negedge clk_i);
    endtask

    // Both lines are low together only for a quarter period.
    task automatic start();
        sda_low_o = 1'b0;
        quarter();
        scl_o = 1'b1;
        quarter();
        sda_low_o = 1'b1;
        quarter();
        scl_o = 1'b0;
        quarter();
    endtask

    task automatic stop();
        sda_low_o = 1'b1;
        quarter();
        scl_o = 1'b1;
        quarter();
        sda_low_o = 1'b0;
        quarter();
    endtask

    task automatic xfer_bit(input logic b, output logic seen);
        sda_low_o = ~b;
        quarter();
        scl_o = 1'b1;
        quarter();
        seen = sda_i;
        quarter();
        scl_o = 1'b0;
        quarter();
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], s);
        xfer_bit(1'b1, s);
        ack = ~s;
    endtask

    // The final byte of a read is refused so the slave lets go.
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(1'b1, s);
            d[i] = s;
        end
        xfer_bit(last, s);
    endtask
endmodule

// File: testbench/accel_event_status_regs_test.sv
`timescale 1ns/1ns
module accel_event_status_regs_test;
    import accel_evt_pkg::*;

    localparam logic [6:0] DEV_ADDR = 7'h15;
    localparam logic signed [11:0] AX [7] = '{12'h258, 12'h000, 12'hCE0,
        12'h005, 12'h180, 12'h181, 12'hF9C};
    localparam logic signed [11:0] AY [7] = '{12'h000, 12'hD44, 12'h00A,
        12'h1F4, 12'h000, 12'h000, 12'hED4};
    localparam logic [1:0] CODE [7] = '{XY_POS_X, XY_NEG_Y, XY_NEG_X,
        XY_POS_Y, XY_POS_Y, XY_POS_X, XY_POS_X};

    logic          clk_i;
    logic          rst_i;
    logic          scl;
    logic          m_low;
    logic          sda_w;
    logic          sda_o;
    logic          sda_oe_o;
    logic          int_o;
    logic          soft_reset_o;
    logic          soft_seen;
    logic          sample_valid_i;
    logic [3:0]    shake_det_i;
    accel_sample_t sample_i;
    irq_enable_t   irq_enable_i;
    int            errors;
    int            checks;

    // Wired bus with pull-up: low whenever either side pulls.
    assign sda_w = ~(sda_oe_o | m_low);

    accel_event_status_regs #(.SLAVE_ADDR(DEV_ADDR)) uut (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .scl_i          (scl),
        .sda_i          (sda_w),
        .sda_o          (sda_o),
        .sda_oe_o       (sda_oe_o),
        .shake_det_i    (shake_det_i),
        .sample_valid_i (sample_valid_i),
        .sample_i       (sample_i),
        .irq_enable_i   (irq_enable_i),
        .int_o          (int_o),
        .soft_reset_o   (soft_reset_o)
    );

    i2c_master_model u_master (
        .clk_i     (clk_i),
        .sda_i     (sda_w),
        .scl_o     (scl),
        .sda_low_o (m_low)
    );

    always @(posedge clk_i)
        if (soft_reset_o)
            soft_seen <= 1'b1;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // With n of 2 the upper byte goes first.
    task automatic reg_write(input logic [7:0] p, input logic [15:0] d,
                             input int n);
        logic a;
        u_master.start();
        u_master.wr_byte({DEV_ADDR, 1'b0}, a);
        u_master.wr_byte(p, a);
        for (int k = 0; k < n; k++)
        begin
            u_master.wr_byte(k < n - 1 ? d[15:8] : d[7:0], a);
            check(a, 1'b1);
        end
        u_master.stop();
    endtask

    task automatic reg_read(input logic [7:0] p, input int n,
                            output logic [15:0] d);
        logic       a;
        logic [7:0] b;
        d = 16'h0000;
        u_master.start();
        u_master.wr_byte({DEV_ADDR, 1'b0}, a);
        u_master.wr_byte(p, a);
        u_master.start();
        u_master.wr_byte({DEV_ADDR, 1'b1}, a);
        for (int k = 0; k < n; k++)
        begin
            u_master.rd_byte(k == n - 1, b);
            d = {d[7:0], b};
        end
        u_master.stop();
    endtask

    task automatic pulse(input logic [3:0] v);
        @(negedge clk_i);
        shake_det_i = v;
        @(negedge clk_i);
        shake_det_i = 4'h0;
        repeat (2) @(negedge clk_i);
    endtask

    task automatic t_reset();
        logic [15:0] d;
        logic        a;
        reg_read(EVT_REG_OFS, 2, d);
        check(d, 16'h0000);
        reg_read(LAST_REG_OFS, 1, d);
        check(d, 16'h0000);
        u_master.start();
        u_master.wr_byte({7'h2A, 1'b0}, a);
        u_master.stop();
        check(a, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_shake();
        logic [15:0] d;
        pulse(4'h1);
        check(int_o, 1'b0);
        irq_enable_i = 7'h7F;
        repeat (3) @(negedge clk_i);
        check(int_o, 1'b1);
        pulse(4'hA);
        reg_read(EVT_REG_OFS, 1, d);
        check(d, 16'h000B);
        reg_write(EVT_REG_OFS, 16'h0001, 1);
        reg_read(EVT_REG_OFS, 1, d);
        check(d, 16'h000A);
        pulse(4'h1);
        reg_read(EVT_REG_OFS, 1, d);
        check(d, 16'h000B);
        reg_write(EVT_REG_OFS, 16'h000B, 1);
        reg_read(EVT_REG_OFS, 1, d);
        check(d, 16'h0000);
        check(int_o, 1'b0);
        $display("test shake done");
    endtask

    task automatic t_orient();
        logic [15:0] d;
        logic [1:0]  pc;
        logic        pz;
        pc = XY_POS_X;
        pz = 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            @(negedge clk_i);
            sample_i = '{AX[i], AY[i], i[0], i[1]};
            sample_valid_i = 1'b1;
            @(negedge clk_i);
            sample_valid_i = 1'b0;
            reg_read(EVT_REG_OFS, 2, d);
            check(d[15:8], {i[0] != pz, CODE[i] != pc, 6'h00});
            check(d[7:0], {i[1], i[0], CODE[i], 4'h1});
            reg_write(EVT_REG_OFS, 16'hC001, 2);
            pc = CODE[i];
            pz = i[0];
        end
        reg_read(EVT_REG_OFS, 2, d);
        check(d, 16'h0080);
        reg_read(8'h05, 1, d);
        check(d, 16'h0000);
        $display("test orientation done");
    endtask

    task automatic t_soft();
        logic [15:0] d;
        pulse(4'h3);
        soft_seen = 1'b0;
        reg_write(ORI_REG_OFS, 16'h0010, 1);
        repeat (4) @(negedge clk_i);
        check(soft_seen, 1'b1);
        reg_read(EVT_REG_OFS, 2, d);
        check(d, 16'h0000);
        check(int_o, 1'b0);
        $display("test soft reset done");
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial
    begin
        rst_i = 1'b1;
        shake_det_i = 4'h0;
        sample_valid_i = 1'b0;
        sample_i = '0;
        irq_enable_i = '0;
        soft_seen = 1'b0;
        errors = 0;
        checks = 0;
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        t_reset();
        t_shake();
        t_orient();
        t_soft();
        results();
    end

    // The tests need about 8600 cycles; this leaves ample margin.
    initial
    begin
        repeat (40000) @(posedge clk_i);
        errors++;
        results();
    end
endmodule
